// ===== src/asc_pkg.sv
package asc_pkg;
  // Array geometry and core clock period
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 50;
  // Slower grade figures, covering both grades
  localparam int T_RC_NS = 15;
  localparam int T_AA_NS = 15;
  localparam int T_PWE_NS = 10;
  localparam int T_SD_NS = 8;
  localparam int T_HZWE_NS = 7;
  localparam int T_HZOE_NS = 6;
  localparam int T_PD_NS = 15;
  // Least times round up
  localparam int RD_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WE_CYC = (T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SD_CYC = (T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HZ_CYC = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] WE_CNT = CNT_W'(WE_CYC);
  localparam logic [CNT_W-1:0] HZ_CNT = CNT_W'(HZ_CYC);
  localparam logic [CNT_W-1:0] REC_CNT = CNT_W'(REC_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

  typedef enum logic [2:0] {
    ASC_IDLE = 3'b000,
    ASC_READ = 3'b001,
    ASC_TURN = 3'b010,
    ASC_WSET = 3'b011,
    ASC_WSTB = 3'b100,
    ASC_WEND = 3'b101,
    ASC_HOLD = 3'b110
  } asc_state_e;

  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } asc_pins_s;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asc_req_s;

  localparam asc_pins_s PINS_IDLE = '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
    addr: '0, dq_out: '0, dq_oe: 1'b0};
endpackage

// ===== src/asc_sync.sv
`timescale 1ns/1ps
module asc_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [asc_pkg::DATA_W-1:0] d,
  output logic [asc_pkg::DATA_W-1:0] q
);
  import asc_pkg::*;
  logic [DATA_W-1:0] s1_q, s1_d, q_d;

  always_comb begin
    s1_d = d;
    q_d = s1_q;
    if (rst) begin
      s1_d = '0;
      q_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    s1_q <= s1_d;
    q <= q_d;
  end
endmodule // asc_sync

// ===== src/asc_host.sv
`timescale 1ns/1ps
// Function
// - Read: strobe high, select and drive low
// - Strobe-ended write stores on strobe rise
// - Select-ended write stores on select rise
// - Never drive while memory drives bus
// - Address valid before select falls for writes; a read sets address and select on one edge
// - Retention: deselected, recover one read cycle
module asc_host (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire asc_pkg::asc_req_s req,
  output logic req_ready,
  output logic rd_valid,
  output logic [asc_pkg::DATA_W-1:0] rd_data,
  input wire logic retain,
  output asc_pkg::asc_pins_s pins,
  input wire logic [asc_pkg::DATA_W-1:0] dq_in
);
  import asc_pkg::*;

  asc_state_e st_q, st_d;
  asc_pins_s pins_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic ready_d, rdv_d;
  logic [DATA_W-1:0] rdat_d;
  logic [DATA_W-1:0] dq_sync;
  logic ret_q, ret_d;

  // Pin data is asynchronous; two flops before use
  asc_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d(dq_in),
    .q(dq_sync)
  );

  always_comb begin
    st_d = st_q;
    pins_d = pins;
    cnt_d = cnt_q;
    ready_d = 1'b0;
    rdv_d = 1'b0;
    rdat_d = rd_data;
    ret_d = retain;
    case (st_q)
      ASC_IDLE: begin
        pins_d = PINS_IDLE;
        if (cnt_q != CNT_ZERO) begin
          cnt_d = cnt_q - 3'h1;
        end else if (ret_q) begin
          cnt_d = REC_CNT;
        end else if (req_valid) begin
          pins_d.addr = req.addr;
          if (req.wr) begin
            st_d = ASC_WSET;
          end else begin
            pins_d.cs_n = 1'b0;
            pins_d.oe_n = 1'b0;
            cnt_d = RD_CNT;
            st_d = ASC_READ;
          end
          pins_d.dq_out = req.wdata;
        end else begin
          ready_d = 1'b1;
        end
      end
      ASC_READ: begin
        if (cnt_q != CNT_ZERO) begin
          cnt_d = cnt_q - 3'h1;
        end else begin
          rdat_d = dq_sync;
          rdv_d = 1'b1;
          pins_d.oe_n = 1'b1;
          pins_d.cs_n = 1'b1;
          cnt_d = HZ_CNT;
          st_d = ASC_TURN;
        end
      end
      ASC_TURN: begin
        // Wait for memory outputs to float before anything else
        if (cnt_q != CNT_ZERO) begin
          cnt_d = cnt_q - 3'h1;
        end else begin
          st_d = ASC_IDLE;
          ready_d = ~ret_q;
        end
      end
      ASC_WSET: begin
        // Outputs stay off, address already set before strobe
        pins_d.cs_n = 1'b0;
        pins_d.we_n = 1'b0;
        pins_d.dq_oe = 1'b1;
        cnt_d = WE_CNT;
        st_d = ASC_WSTB;
      end
      ASC_WSTB: begin
        if (cnt_q != CNT_ZERO) begin
          cnt_d = cnt_q - 3'h1;
        end else begin
          pins_d.we_n = 1'b1;
          st_d = ASC_WEND;
        end
      end
      ASC_WEND: begin
        // Data held one edge after strobe rise, then released
        pins_d.cs_n = 1'b1;
        pins_d.dq_oe = 1'b0;
        st_d = ASC_HOLD;
      end
      ASC_HOLD: begin
        pins_d = PINS_IDLE;
        st_d = ASC_IDLE;
        ready_d = ~ret_q;
      end
      default: begin
        st_d = ASC_IDLE;
        pins_d = PINS_IDLE;
      end
    endcase
    if (rst) begin
      st_d = ASC_IDLE;
      pins_d = PINS_IDLE;
      cnt_d = CNT_ZERO;
      ready_d = 1'b0;
      rdv_d = 1'b0;
      rdat_d = '0;
      ret_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    st_q <= st_d;
    pins <= pins_d;
    cnt_q <= cnt_d;
    req_ready <= ready_d;
    rd_valid <= rdv_d;
    rd_data <= rdat_d;
    ret_q <= ret_d;
  end

  a_drive_idle_cs: assert property (@(posedge core_clk) disable iff (rst)
    pins.dq_oe |-> (pins.oe_n && !pins.cs_n))
    else $error("host drives bus while memory may drive");
  a_read_strobe: assert property (@(posedge core_clk) disable iff (rst)
    !pins.oe_n |-> pins.we_n)
    else $error("strobe low during read");
  a_write_addr_stable: assert property (@(posedge core_clk) disable iff (rst)
    (!pins.we_n && $past(!pins.we_n)) |-> $stable(pins.addr))
    else $error("address moved during write");
  a_write_data_stable: assert property (@(posedge core_clk) disable iff (rst)
    $rose(pins.we_n) |-> pins.dq_oe && $stable(pins.dq_out))
    else $error("write data not held at strobe end");
  a_read_length: assert property (@(posedge core_clk) disable iff (rst)
    $fell(pins.cs_n) && pins.we_n |-> !pins.oe_n [*3] ##1 rd_valid)
    else $error("read length wrong");
  a_strobe_in_select: assert property (@(posedge core_clk) disable iff (rst)
    !pins.we_n |-> !pins.cs_n)
    else $error("strobe outside select");
  a_retain_desel: assert property (@(posedge core_clk) disable iff (rst)
    (ret_q && st_q == ASC_IDLE) |-> pins.cs_n)
    else $error("select during retention");
  a_addr_at_sel: assert property (@(posedge core_clk) disable iff (rst)
    !pins.cs_n && $past(!pins.cs_n) |-> $stable(pins.addr))
    else $error("address changed while selected");
  a_turnaround: assert property (@(posedge core_clk) disable iff (rst)
    $rose(pins.oe_n) |-> !pins.dq_oe [*2])
    else $error("no turnaround after read");

  c_read: cover property (@(posedge core_clk) rd_valid);
  c_write: cover property (@(posedge core_clk) $rose(pins.we_n));
  c_retain: cover property (@(posedge core_clk) ret_q && req_valid);
endmodule // asc_host

// ===== testbench/asc_sram_model.sv
`timescale 1ns/1ps
module asc_sram_model (
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [asc_pkg::ADDR_W-1:0] addr,
  input wire logic [asc_pkg::DATA_W-1:0] dq,
  output logic [asc_pkg::DATA_W-1:0] q,
  output logic q_oe
);
  import asc_pkg::*;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last = 8'h00;
  assign q_oe = !cs_n && we_n && !oe_n;
  always @(posedge we_n) if (!cs_n) mem[addr] = dq;
  always @(posedge cs_n) if (!we_n) mem[addr] = dq;
  // Released bus shows a changed value, never the old byte
  always @* begin
    if (q_oe) begin
      q = mem[addr];
      last = mem[addr];
    end else begin
      q = ~last;
    end
  end
endmodule // asc_sram_model

// ===== testbench/asc_host_tb.sv
`timescale 1ns/1ps
module asc_host_tb;
  import asc_pkg::*;
  logic core_clk, rst, req_valid, retain, req_ready, rd_valid, q_oe;
  asc_req_s req;
  asc_pins_s pins;
  logic [DATA_W-1:0] rd_data, q, dq;
  int err_total, samples_checked;
  assign dq = pins.dq_oe ? pins.dq_out : q;
  asc_host i_asc_host (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .retain(retain),
    .pins(pins), .dq_in(dq));
  asc_sram_model i_asc_sram_model (.cs_n(pins.cs_n), .we_n(pins.we_n), .oe_n(pins.oe_n),
    .addr(pins.addr), .dq(dq), .q(q), .q_oe(q_oe));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hold the request until the memory is selected
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    req <= '{wr: wr, addr: a, wdata: d};
    req_valid <= 1'b1;
    for (int i = 0; i < 40 && pins.cs_n !== 1'b0; i++) @(posedge core_clk);
    check({1'b0, pins.addr}, {1'b0, a});
    req_valid <= 1'b0;
  endtask
  task automatic write_byte(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    issue(1'b1, a, d);
    repeat (6) @(posedge core_clk);
    check({14'h0, pins.cs_n, pins.dq_oe}, 16'h2);
  endtask
  task automatic read_byte(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    issue(1'b0, a, 8'h00);
    for (int i = 0; i < 20 && rd_valid !== 1'b1; i++) @(posedge core_clk);
    check({8'h0, rd_data}, {8'h0, exp});
    @(posedge core_clk);
  endtask
  task automatic t_boundary;
    write_byte(15'h0000, 8'ha5);
    write_byte(15'h7fff, 8'h5a);
    write_byte(15'h1234, 8'h3c);
    write_byte(15'h1234, 8'hc3);
    read_byte(15'h7fff, 8'h5a);
    read_byte(15'h0000, 8'ha5);
    read_byte(15'h1234, 8'hc3);
  endtask
  task automatic t_retain;
    retain <= 1'b1;
    // Let the design see retention before a request stands
    repeat (2) @(posedge core_clk);
    req <= '{wr: 1'b1, addr: 15'h0042, wdata: 8'h99};
    req_valid <= 1'b1;
    repeat (20) begin
      @(posedge core_clk);
      check({15'h0, pins.cs_n}, 16'h1);
    end
    retain <= 1'b0;
    write_byte(15'h0042, 8'h99);
    read_byte(15'h0042, 8'h99);
  endtask
  // Host and memory never fight over the bus
  always @(posedge core_clk) if (!rst) check({15'h0, pins.dq_oe & q_oe}, 16'h0);
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    retain = 1'b0;
    req = '0;
    err_total = 0;
    samples_checked = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({12'h0, pins.cs_n, pins.we_n, pins.oe_n, pins.dq_oe}, 16'he);
    t_boundary();
    t_retain();
    wrap_up();
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    err_total++;
    wrap_up();
  end
endmodule // asc_host_tb
